// file: ppr_cfg.svh
// register map, reset values, selector codes and timing for the process pid regulator
`ifndef PPR_CFG_SVH
`define PPR_CFG_SVH

// register indices on the plain register port
`define PPR_A_REF_SEL   4'h0
`define PPR_A_DIG_REF   4'h1
`define PPR_A_FB_SEL    4'h2
`define PPR_A_POLARITY  4'h3
`define PPR_A_KP        4'h4
`define PPR_A_TI        4'h5
`define PPR_A_TD        4'h6
`define PPR_A_PERIOD    4'h7
`define PPR_A_UPPER     4'h8
`define PPR_A_LOWER     4'h9
`define PPR_A_FREQ_A    4'hA
`define PPR_A_FREQ_B    4'hB
`define PPR_A_VOLT_CH   4'hC
`define PPR_A_OUT       4'hD
`define PPR_A_STATUS    4'hE

// reset values: gain 1.80, integral 0.90 s, sampling 100 ms, limits 100.0 / 0.0 %
`define PPR_RST_ZERO    16'h0000
`define PPR_RST_KP      16'h00B4
`define PPR_RST_TI      16'h005A
`define PPR_RST_PERIOD  16'h0064
`define PPR_RST_UPPER   16'sh03E8

// percent range in 0.1 % steps
`define PPR_PCT_MAX     16'sh03E8
`define PPR_PCT_MIN     16'shFC18

// selector codes that put the drive into process regulation
`define PPR_MODE_FREQ   16'h0007
`define PPR_MODE_VOLT   16'h0006

// reference source codes
`define PPR_REF_DIGITAL 16'h0000
`define PPR_REF_AIN1    16'h0001
`define PPR_REF_AIN2    16'h0002
`define PPR_REF_AIN3    16'h0003
`define PPR_REF_PULSE1  16'h0004
`define PPR_REF_MSTEP   16'h0005
`define PPR_REF_MODBUS  16'h0006
`define PPR_REF_FIELD   16'h0007
`define PPR_REF_ETH     16'h0008
`define PPR_REF_PULSE2  16'h0009
`define PPR_REF_RTNET   16'h000A
`define PPR_REF_EXPCARD 16'h000B

// feedback source codes
`define PPR_FB_AIN1     16'h0000
`define PPR_FB_AIN2     16'h0001
`define PPR_FB_AIN3     16'h0002
`define PPR_FB_PULSE1   16'h0003
`define PPR_FB_MODBUS   16'h0004
`define PPR_FB_FIELD    16'h0005
`define PPR_FB_ETH      16'h0006
`define PPR_FB_PULSE2   16'h0007
`define PPR_FB_RTNET    16'h0008
`define PPR_FB_EXPCARD  16'h0009
`define PPR_FB_RESERVED 16'h000A

// arithmetic scales: integral and derivative times in 10 ms, gain in 0.01
`define PPR_TIME_SCALE  32'h0000000A
`define PPR_TD_SCALE    21'h00000A
`define PPR_KP_SCALE    32'h00000064
`define PPR_S32_MAX     32'sh7FFFFFFF
`define PPR_SMALL_ACC   12'h000

// clock period and one millisecond, both in ns
`define PPR_CLK_NS      8
`define PPR_MS_NS       1000000

`endif

// file: ppr_div.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps

module ppr_div #(
  parameter int unsigned NW = 48,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quotient
);
  localparam int unsigned CW = $clog2(NW + 1);

  typedef struct packed {
    logic [DW-1:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
  } ppr_div_state_t;

  ppr_div_state_t st, next_st;

  // start is ignored while busy; a zero divisor is taken as one
  always_comb begin
    logic [DW:0] trial;
    trial = '0;
    next_st = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      trial = {st.rem, st.quo[NW-1]};
      next_st.quo = {st.quo[NW-2:0], 1'b0};
      if (trial >= {1'b0, st.den}) begin
        trial = trial - {1'b0, st.den};
        next_st.quo[0] = 1'b1;
      end
      next_st.rem = trial[DW-1:0];
      next_st.cnt = st.cnt + CW'(1);
      if (st.cnt == CW'(NW - 1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end else if (start) begin
      next_st.rem  = '0;
      next_st.quo  = dividend;
      next_st.den  = (divisor == '0) ? DW'(1) : divisor;
      next_st.cnt  = '0;
      next_st.busy = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy     = st.busy;
  assign done     = st.done;
  assign quotient = st.quo;
endmodule

// file: ppr_limit.sv
// clamps a wide signed value into the output limit window
`timescale 1ns/1ps

module ppr_limit #(
  parameter int unsigned W = 32
) (
  input  wire logic signed [W-1:0] value,
  input  wire logic signed [15:0]  upper,
  input  wire logic signed [15:0]  lower,
  output logic signed [15:0]       clamped
);
  // if software ever leaves the window inverted, a value above upper gives upper and any other value gives lower
  always_comb begin
    if (value > upper) begin
      clamped = upper;
    end else if (value < lower) begin
      clamped = lower;
    end else begin
      clamped = value[15:0];
    end
  end
endmodule

// file: ppr_pkg.sv
// types shared by the process pid regulator files
package ppr_pkg;

  typedef enum logic [3:0] {
    PPR_IDLE  = 4'h1,
    PPR_DIV_I = 4'h2,
    PPR_DIV_D = 4'h4,
    PPR_DIV_O = 4'h8
  } ppr_fsm_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ppr_bus_t;

  // signal sources, signed 0.1 % units
  typedef struct packed {
    logic signed [15:0] ain1, ain2, ain3, pulse1, pulse2, mstep;
    logic signed [15:0] modbus, field, eth, rtnet, expcard;
  } ppr_src_t;

  typedef struct packed {
    logic [15:0]        ref_sel, fb_sel, polarity, kp, ti, td, period;
    logic [15:0]        freq_a, freq_b, volt_ch, ms, rdata;
    logic signed [15:0] dig_ref, upper, lower, out;
    ppr_fsm_t           fsm;
    logic [31:0]        pre;
    logic               tick, mode, out_valid, qneg;
    logic signed [31:0] acc, i_term, d_term;
    logic signed [17:0] err;
    logic signed [18:0] derr;
  } ppr_state_t;

endpackage

// file: ppr_regulator.sv
// process pid regulator: register file, sampling timer and pid engine
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ppr_cfg.svh"

module ppr_regulator
  import ppr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `PPR_MS_NS / `PPR_CLK_NS
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire ppr_bus_t           bus,
  output logic [15:0]             reg_rdata,
  input  wire ppr_src_t           src,
  output logic signed [15:0]      reg_out,
  output logic                    out_valid,
  output logic                    process_mode
);
  localparam logic [31:0] CYC_M1 = 32'(CYC_PER_MS - 1);

  ppr_state_t         st, next_st;
  logic signed [15:0] ref_val, fb_val, lim_out;
  logic signed [17:0] e_new;
  logic signed [31:0] q_signed;
  logic               tick_take, div_start, div_busy, div_done;
  logic [47:0]        div_num, div_quo;
  logic [31:0]        div_den;

  function automatic logic signed [15:0] pick_ref(input logic [15:0] code,
                                                  input logic signed [15:0] dig,
                                                  input ppr_src_t s);
    logic signed [15:0] v;
    v = 16'sh0000;
    case (code)
      `PPR_REF_DIGITAL: v = dig;
      `PPR_REF_AIN1:    v = s.ain1;
      `PPR_REF_AIN2:    v = s.ain2;
      `PPR_REF_AIN3:    v = s.ain3;
      `PPR_REF_PULSE1:  v = s.pulse1;
      `PPR_REF_MSTEP:   v = s.mstep;
      `PPR_REF_MODBUS:  v = s.modbus;
      `PPR_REF_FIELD:   v = s.field;
      `PPR_REF_ETH:     v = s.eth;
      `PPR_REF_PULSE2:  v = s.pulse2;
      `PPR_REF_RTNET:   v = s.rtnet;
      `PPR_REF_EXPCARD: v = s.expcard;
      default:          v = 16'sh0000; // reserved code reads as zero
    endcase
    return v;
  endfunction

  function automatic logic signed [15:0] pick_fb(input logic [15:0] code,
                                                 input ppr_src_t s);
    logic signed [15:0] v;
    v = 16'sh0000;
    case (code)
      `PPR_FB_AIN1:    v = s.ain1;
      `PPR_FB_AIN2:    v = s.ain2;
      `PPR_FB_AIN3:    v = s.ain3;
      `PPR_FB_PULSE1:  v = s.pulse1;
      `PPR_FB_MODBUS:  v = s.modbus;
      `PPR_FB_FIELD:   v = s.field;
      `PPR_FB_ETH:     v = s.eth;
      `PPR_FB_PULSE2:  v = s.pulse2;
      `PPR_FB_RTNET:   v = s.rtnet;
      `PPR_FB_EXPCARD: v = s.expcard;
      default:         v = 16'sh0000; // reserved code reads as zero
    endcase
    return v;
  endfunction

  // symmetric saturation keeps later negation safe
  function automatic logic signed [31:0] sat_add(input logic signed [33:0] v);
    if (v > `PPR_S32_MAX) begin
      return `PPR_S32_MAX;
    end else if (v < -`PPR_S32_MAX) begin
      return -`PPR_S32_MAX;
    end
    return v[31:0];
  endfunction

  function automatic logic [47:0] mag(input logic signed [48:0] v);
    logic signed [48:0] a;
    a = v[48] ? -v : v;
    return a[47:0];
  endfunction

  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v > hi) begin
      return hi;
    end else if (v < lo) begin
      return lo;
    end
    return v;
  endfunction

  // source selection and signed deviation
  assign ref_val   = pick_ref(st.ref_sel, st.dig_ref, src);
  assign fb_val    = pick_fb(st.fb_sel, src);
  assign e_new     = st.polarity[0] ? 18'(fb_val) - 18'(ref_val)
                                    : 18'(ref_val) - 18'(fb_val);
  assign tick_take = st.tick && st.mode && (st.fsm == PPR_IDLE);
  // quotient saturated on its full width; a narrowing cast first would wrap it
  assign q_signed  = (div_quo[47:31] != 17'h00000) ? (st.qneg ? -`PPR_S32_MAX : `PPR_S32_MAX)
                   : st.qneg ? -$signed({1'b0, div_quo[30:0]})
                             : $signed({1'b0, div_quo[30:0]});

  always_comb begin
    logic signed [48:0] prod;
    logic signed [33:0] wide;
    prod = '0;
    wide = '0;
    next_st = st;
    next_st.tick = 1'b0;
    next_st.out_valid = 1'b0;
    next_st.rdata = 16'h0000;
    div_start = 1'b0;
    div_num = 48'h000000000000;
    div_den = 32'h00000001;
    next_st.mode = (st.freq_a == `PPR_MODE_FREQ) || (st.freq_b == `PPR_MODE_FREQ)
                || (st.volt_ch == `PPR_MODE_VOLT);

    // millisecond prescaler, then sampling period in ms; zero behaves as one
    if (st.pre == CYC_M1) begin
      next_st.pre = 32'h00000000;
      if (({1'b0, st.ms} + 17'h00001) >= {1'b0, st.period}) begin
        next_st.ms = 16'h0000;
        next_st.tick = 1'b1;
      end else begin
        next_st.ms = st.ms + 16'h0001;
      end
    end else begin
      next_st.pre = st.pre + 32'h00000001;
    end

    // register writes; limits keep lower no higher than upper
    if (bus.wr) begin
      case (bus.addr)
        `PPR_A_REF_SEL:  next_st.ref_sel = bus.wdata;
        `PPR_A_DIG_REF:  next_st.dig_ref = clamp16(bus.wdata, `PPR_PCT_MIN, `PPR_PCT_MAX);
        `PPR_A_FB_SEL:   next_st.fb_sel = bus.wdata;
        `PPR_A_POLARITY: next_st.polarity = bus.wdata;
        `PPR_A_KP:       next_st.kp = bus.wdata;
        `PPR_A_TI:       next_st.ti = bus.wdata;
        `PPR_A_TD:       next_st.td = bus.wdata;
        `PPR_A_PERIOD:   next_st.period = bus.wdata;
        `PPR_A_UPPER:    next_st.upper = clamp16(bus.wdata, st.lower, `PPR_PCT_MAX);
        `PPR_A_LOWER:    next_st.lower = clamp16(bus.wdata, `PPR_PCT_MIN, st.upper);
        `PPR_A_FREQ_A:   next_st.freq_a = bus.wdata;
        `PPR_A_FREQ_B:   next_st.freq_b = bus.wdata;
        `PPR_A_VOLT_CH:  next_st.volt_ch = bus.wdata;
        default:         next_st.rdata = 16'h0000; // read-only or unmapped
      endcase
    end

    // read data stands only in the cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        `PPR_A_REF_SEL:  next_st.rdata = st.ref_sel;
        `PPR_A_DIG_REF:  next_st.rdata = st.dig_ref;
        `PPR_A_FB_SEL:   next_st.rdata = st.fb_sel;
        `PPR_A_POLARITY: next_st.rdata = st.polarity;
        `PPR_A_KP:       next_st.rdata = st.kp;
        `PPR_A_TI:       next_st.rdata = st.ti;
        `PPR_A_TD:       next_st.rdata = st.td;
        `PPR_A_PERIOD:   next_st.rdata = st.period;
        `PPR_A_UPPER:    next_st.rdata = st.upper;
        `PPR_A_LOWER:    next_st.rdata = st.lower;
        `PPR_A_FREQ_A:   next_st.rdata = st.freq_a;
        `PPR_A_FREQ_B:   next_st.rdata = st.freq_b;
        `PPR_A_VOLT_CH:  next_st.rdata = st.volt_ch;
        `PPR_A_OUT:      next_st.rdata = st.out;
        `PPR_A_STATUS:   next_st.rdata = {14'h0000, st.fsm != PPR_IDLE, st.mode};
        default:         next_st.rdata = 16'h0000;
      endcase
    end

    // pid engine: three divides share one serial divider
    unique case (st.fsm)
      PPR_IDLE: begin
        if (tick_take) begin
          next_st.err  = e_new;
          next_st.derr = 19'(e_new) - 19'(st.err);
          if (st.ti == 16'h0000) begin
            next_st.acc = 32'sh00000000;
          end else begin
            next_st.acc = sat_add(34'(st.acc) + 34'(e_new));
          end
          prod = 49'(next_st.acc) * 49'($signed({1'b0, st.period}));
          next_st.qneg = prod[48];
          div_num   = mag(prod);
          div_den   = {16'h0000, st.ti} * `PPR_TIME_SCALE;
          div_start = 1'b1;
          next_st.fsm = PPR_DIV_I;
        end else if (!st.mode) begin
          // leaving regulation drops history so re-entry starts clean
          next_st.acc  = 32'sh00000000;
          next_st.err  = 18'sh00000;
          next_st.derr = 19'sh00000;
          next_st.out  = 16'sh0000;
        end
      end
      PPR_DIV_I: begin
        if (div_done) begin
          next_st.i_term = (st.ti == 16'h0000) ? 32'sh00000000 : q_signed;
          prod = 49'(st.derr) * 49'($signed({1'b0, 21'(st.td) * `PPR_TD_SCALE}));
          next_st.qneg = prod[48];
          div_num   = mag(prod);
          div_den   = {16'h0000, st.period};
          div_start = 1'b1;
          next_st.fsm = PPR_DIV_D;
        end
      end
      PPR_DIV_D: begin
        if (div_done) begin
          next_st.d_term = (st.td == 16'h0000) ? 32'sh00000000 : q_signed;
          wide = 34'(st.err) + 34'(st.i_term) + 34'(next_st.d_term);
          prod = 49'(sat_add(wide)) * 49'($signed({1'b0, st.kp}));
          next_st.qneg = prod[48];
          div_num   = mag(prod);
          div_den   = `PPR_KP_SCALE;
          div_start = 1'b1;
          next_st.fsm = PPR_DIV_O;
        end
      end
      PPR_DIV_O: begin
        if (div_done) begin
          next_st.out = lim_out;
          next_st.out_valid = 1'b1;
          next_st.fsm = PPR_IDLE;
        end
      end
      default: next_st.fsm = PPR_IDLE; // recover from a corrupted code
    endcase
  end

  // all state in one register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.fsm      <= PPR_IDLE;
      st.kp       <= `PPR_RST_KP;
      st.ti       <= `PPR_RST_TI;
      st.td       <= `PPR_RST_ZERO;
      st.period   <= `PPR_RST_PERIOD;
      st.upper    <= `PPR_RST_UPPER;
      st.polarity <= `PPR_RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  ppr_div #(
    .NW (48),
    .DW (32)
  ) u_div (
    .clk      (clk),
    .rst      (rst),
    .start    (div_start),
    .dividend (div_num),
    .divisor  (div_den),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quo)
  );

  ppr_limit #(
    .W (32)
  ) u_limit (
    .value   (q_signed),
    .upper   (st.upper),
    .lower   (st.lower),
    .clamped (lim_out)
  );

  assign reg_rdata    = st.rdata;
  assign reg_out      = st.out;
  assign out_valid    = st.out_valid;
  assign process_mode = st.mode;

  // checks on the engine
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_mode_decode: assert property (
    st.mode == (($past(st.freq_a) == `PPR_MODE_FREQ) || ($past(st.freq_b) == `PPR_MODE_FREQ)
             || ($past(st.volt_ch) == `PPR_MODE_VOLT)))
    else $error("mode flag does not follow selectors");
  a_prop_gain: assert property (
    (st.out_valid && st.ti == 16'h0000 && st.td == 16'h0000 && st.kp == `PPR_KP_SCALE
     && st.err <= st.upper && st.err >= st.lower) |-> st.out == st.err)
    else $error("unit gain output differs from deviation");
  a_integ_step: assert property (
    (tick_take && st.ti != 16'h0000 && st.acc[31:20] == `PPR_SMALL_ACC)
    |=> st.acc == $past(st.acc) + $past(e_new))
    else $error("integral did not accumulate deviation");
  a_deriv_diff: assert property (
    tick_take |=> st.derr == $past(e_new) - $past(st.err))
    else $error("derivative input is not deviation change");
  a_integ_off: assert property (
    (tick_take && st.ti == 16'h0000) |=> st.acc == 32'sh00000000)
    else $error("integral active with zero time");
  a_ref_digital: assert property (
    st.ref_sel == `PPR_REF_DIGITAL |-> ref_val == st.dig_ref)
    else $error("digital reference not selected");
  a_fb_reserved: assert property (
    st.fb_sel == `PPR_FB_RESERVED |-> fb_val == 16'sh0000)
    else $error("reserved feedback code not zero");
  a_err_polarity: assert property (
    tick_take |=> st.err == ($past(st.polarity[0]) ? $past(fb_val) - $past(ref_val)
                                                   : $past(ref_val) - $past(fb_val)))
    else $error("deviation sign ignores polarity");
  a_out_upper: assert property (
    st.out_valid |-> st.out <= $past(st.upper))
    else $error("output above upper limit");
  a_out_lower: assert property (
    st.out_valid |-> st.out >= $past(st.lower))
    else $error("output below lower limit");
  a_sample_latency: assert property (
    tick_take |-> ##[1:200] st.out_valid)
    else $error("sample not answered in time");
  a_div_free: assert property (
    tick_take |-> !div_busy)
    else $error("sample taken while divider busy");

  c_mode_entry: cover property ($rose(st.mode));
  c_upper_hit: cover property (st.out_valid && st.out == st.upper);
  c_neg_update: cover property (tick_take && st.polarity[0]);
  c_full_pid: cover property (tick_take && st.ti != 16'h0000 && st.td != 16'h0000);
endmodule

// file: ppr_regulator_tb.sv
// self-checking bench for the process pid regulator
`timescale 1ns/1ps
`include "ppr_cfg.svh"

module ppr_regulator_tb
  import ppr_pkg::*;
;
  typedef struct packed {
    logic [15:0]        rs, fs, pol;
    logic signed [15:0] up, lo, ex;
  } ppr_row_t;

  // selector code to model source index: -1 digital setting, -2 reserved
  localparam int REFIX [13] = '{-1, 0, 1, 2, 3, 5, 6, 7, 8, 4, 9, 10, -2};
  localparam int FBIX  [11] = '{0, 1, 2, 3, 6, 7, 8, 4, 9, 10, -2};
  localparam logic [19:0] MSTEP [6] = '{20'hA0000, 20'hB0007, 20'hB0006,
                                        20'hC0006, 20'hC0007, 20'hA0007};

  logic               clk          = 1'b0;
  logic               rst          = 1'b1;
  ppr_bus_t           bus          = '0;
  logic signed [15:0] bias         = '0;
  ppr_src_t           src;
  logic [15:0]        reg_rdata;
  logic signed [15:0] reg_out, o, p;
  logic               out_valid, process_mode;
  int                 fail_count   = 0;
  int                 total_checks = 0;
  int                 cyc          = 0;
  int                 t0;
  ppr_row_t           rows [$];
  ppr_row_t           r;
  logic [15:0]        d;
  logic [15:0]        rv [16] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00B4, 16'h005A,
                                  16'h0000, 16'h0064, 16'h03E8, 16'h0000, 16'h0000, 16'h0000,
                                  16'h0000, 16'h0000, 16'h0000, 16'h0000};

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  ppr_src_model srcm (.bias(bias), .src(src));

  // short millisecond so sampling periods of 1 ms to 20 ms take 10 to 200 cycles
  ppr_regulator #(.CYC_PER_MS(10)) dut (
    .clk(clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata), .src(src),
    .reg_out(reg_out), .out_valid(out_valid), .process_mode(process_mode)
  );

  function automatic logic signed [15:0] sv(input int ix);
    return ix == -1 ? 16'sh01F4 : ix == -2 ? 16'sh0000 : 16'(10 * (ix + 1));
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data is only valid in the single cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  // next output update, bounded so a dead engine cannot hang the run
  task automatic upd(output logic signed [15:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while (out_valid !== 1'b1) begin
      n++;
      if (n > 400) begin
        fail_count++;
        $display("ERROR %0t no output update", $time);
        complete_run();
      end
      @(negedge clk);
    end
    v = reg_out;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wr(`PPR_A_KP, 16'h0064);
    wr(`PPR_A_TI, 16'h0000);
    wr(`PPR_A_TD, 16'h0000);
    wr(`PPR_A_PERIOD, 16'h0001);
    wr(`PPR_A_LOWER, `PPR_PCT_MIN);
    wr(`PPR_A_DIG_REF, 16'h01F4);
    wr(`PPR_A_FREQ_A, 16'h0007);
    for (int k = 0; k < 13; k++)
      rows.push_back('{16'(k), 16'h000A, 16'h0000, `PPR_PCT_MAX, `PPR_PCT_MIN, sv(REFIX[k])});
    for (int k = 0; k < 10; k++)
      rows.push_back('{16'h0000, 16'(k), 16'h0000, `PPR_PCT_MAX, `PPR_PCT_MIN,
                       16'(500 - sv(FBIX[k]))});
    rows.push_back('{16'h0001, 16'h000A, 16'h0001, `PPR_PCT_MAX, `PPR_PCT_MIN, -16'sd10});
    rows.push_back('{16'h0000, 16'h0000, 16'h0001, `PPR_PCT_MAX, `PPR_PCT_MIN, -16'sd490});
    rows.push_back('{16'h0000, 16'h000A, 16'h0000, 16'sh00C8, `PPR_PCT_MIN, 16'sh00C8});
    rows.push_back('{16'h0000, 16'h000A, 16'h0001, `PPR_PCT_MAX, 16'shFED4, 16'shFED4});
    // first update may come from a sample taken before the writes
    foreach (rows[i]) begin
      r = rows[i];
      wr(`PPR_A_REF_SEL, r.rs);
      wr(`PPR_A_FB_SEL, r.fs);
      wr(`PPR_A_POLARITY, r.pol);
      wr(`PPR_A_UPPER, r.up);
      wr(`PPR_A_LOWER, r.lo);
      upd(o);
      upd(o);
      chk(o === r.ex, "table output mismatch");
    end
    $display("test table done");
    // integral time written last so the accumulator starts from a clean deviation
    wr(`PPR_A_POLARITY, 16'h0000);
    wr(`PPR_A_DIG_REF, 16'h0064);
    wr(`PPR_A_TI, 16'h0001);
    upd(o);
    upd(o);
    upd(p);
    chk(p - o === 16'sh000A, "integral step wrong");
    upd(o);
    chk(o - p === 16'sh000A, "integral step wrong");
    $display("test integral done");
    wr(`PPR_A_TI, 16'h0000);
    wr(`PPR_A_TD, 16'h0001);
    wr(`PPR_A_LOWER, `PPR_PCT_MIN);
    wr(`PPR_A_DIG_REF, 16'h00C8);
    wr(`PPR_A_FB_SEL, 16'h0000);
    upd(o);
    upd(o);
    upd(o);
    chk(o === 16'sh00BE, "steady output wrong");
    @(posedge clk);
    bias <= 16'sh0032;
    upd(o);
    if (o === 16'sh00BE) upd(o);
    chk(o === -16'sd360, "derivative kick wrong");
    upd(o);
    chk(o === 16'sh008C, "derivative not settled");
    $display("test derivative done");
    wr(`PPR_A_PERIOD, 16'h0014);
    upd(o);
    upd(o);
    t0 = cyc;
    upd(o);
    chk(cyc - t0 === 200, "sampling interval wrong");
    wr(`PPR_A_PERIOD, 16'h0001);
    $display("test period done");
    // each step toggles whether a selector holds the regulation code
    for (int k = 0; k < 6; k++) begin
      wr(MSTEP[k][19:16], MSTEP[k][15:0]);
      repeat (2) @(negedge clk); // mode flag follows one cycle after the write
      chk(process_mode === 1'(k % 2), "mode flag wrong");
      if (k == 0) begin
        repeat (200) @(negedge clk);
        chk(reg_out === 16'sh0000, "output kept outside mode");
      end
    end
    $display("test mode done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    chk({reg_rdata, reg_out, out_valid, process_mode} === 34'h0, "outputs in reset");
    @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk(d === rv[a], "reset value wrong");
    end
    wr(`PPR_A_OUT, 16'h1234);
    wr(4'hF, 16'h1234);
    wr(`PPR_A_DIG_REF, 16'h07D0);
    rd(`PPR_A_OUT, d);
    chk(d === 16'h0000, "read-only output written");
    rd(4'hF, d);
    chk(d === 16'h0000, "unmapped read not zero");
    rd(`PPR_A_DIG_REF, d);
    chk(d === 16'h03E8, "digital setting not clamped");
    $display("test reset and registers done");
    complete_run();
  end
endmodule

// file: ppr_src_model.sv
// model of the process signal sources that feed the regulator
`timescale 1ns/1ps

module ppr_src_model
  import ppr_pkg::*;
(
  input  wire logic signed [15:0] bias,
  output ppr_src_t                src
);
  logic [175:0] flat;

  // source k reads bias plus 10*(k+1), so each selector code shows a distinct value
  always_comb begin
    for (int k = 0; k < 11; k++) begin
      flat[(10-k)*16 +: 16] = bias + 16'h000A * 16'(k + 1);
    end
    src = flat;
  end
endmodule
